// ---- verilog/pc_stack_pkg.sv ----
package pc_stack_pkg;

  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int STACK_DEPTH = 8;
  localparam int OPERAND_W = 11;
  localparam int UPPER_FIELD_W = 5;

  localparam logic [8:0] ADDR_PC_LOW = 9'h002;
  localparam logic [8:0] ADDR_UPPER_HOLD = 9'h00a;

  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] UPPER_HOLD_RESET = 8'h00;

  localparam int JUMP_HI_LSB = 3;
  localparam int JUMP_HI_MSB = 4;

  typedef enum logic [2:0] {
    PC_OP_STEP = 3'h0,
    PC_OP_JUMP = 3'h1,
    PC_OP_CALL = 3'h2,
    PC_OP_VECTOR = 3'h3,
    PC_OP_RET = 3'h4,
    PC_OP_HOLD = 3'h5
  } pc_op_t;

  typedef struct packed {
    logic        exec;
    logic        jump;
    logic        call;
    logic        vector;
    logic        ret;
    logic [10:0] operand;
    logic [12:0] vector_addr;
  } pc_ctl_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// ---- verilog/ret_stack.sv ----
`timescale 1ns/1ps
module ret_stack
  import pc_stack_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  output logic      [WIDTH-1:0] top_o
);

  localparam int PTR_W = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("ret_stack depth must be a power of two of at least two");
    end
  end

  // The pointer has no software path and wraps silently, so overflow simply
  // overwrites the oldest entry and no status is kept.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr_r;
  logic [PTR_W-1:0] ptr_nxt;
  logic [PTR_W-1:0] top_idx;

  assign top_idx = ptr_r - PTR_W'(1);
  assign top_o   = mem[top_idx];

  always_comb begin
    ptr_nxt = ptr_r;
    if (push_i) begin
      ptr_nxt = ptr_r + PTR_W'(1);
    end else if (pop_i) begin
      ptr_nxt = ptr_r - PTR_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // Entries need no reset; a return without a call yields stale data.
  always_ff @(posedge clk_sys_i) begin
    if (push_i) begin
      mem[ptr_r] <= push_data_i;
    end
  end

endmodule

// ---- verilog/pc_call_stack.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module pc_call_stack
  import pc_stack_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire pc_ctl_t           ctl_i,
  output logic      [PC_W-1:0]   pc_o,
  output logic      [PC_W-1:0]   ret_addr_o
);

  initial begin
    if (UPPER_FIELD_W + DATA_W != PC_W || OPERAND_W >= PC_W) begin
      $error("pc_call_stack field widths do not compose a 13-bit counter");
    end
  end

  reg_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  logic [PC_W-1:0]   pc_r;
  logic [PC_W-1:0]   pc_nxt;
  logic [DATA_W-1:0] upper_hold_r;
  logic [DATA_W-1:0] upper_hold_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [PC_W-1:0]   ret_addr_r;
  logic [PC_W-1:0]   stack_top;
  pc_op_t            op;

  wire sel_pc_low    = (req.addr == ADDR_PC_LOW);
  wire sel_upper     = (req.addr == ADDR_UPPER_HOLD);
  wire wr_pc_low     = req.wr && sel_pc_low;
  wire wr_upper      = req.wr && sel_upper;
  wire rd_pc_low     = req.rd && sel_pc_low;
  wire rd_upper      = req.rd && sel_upper;

  // The decoder offers one request per instruction; priority only guards
  // against a malformed combination so the counter stays deterministic.
  wire do_vector = ctl_i.exec && ctl_i.vector;
  wire do_call   = ctl_i.exec && !ctl_i.vector && ctl_i.call;
  wire do_jump   = ctl_i.exec && !ctl_i.vector && !ctl_i.call && ctl_i.jump;
  wire do_ret    = ctl_i.exec && !ctl_i.vector && !ctl_i.call && !ctl_i.jump
                   && ctl_i.ret;

  wire push = do_call || do_vector;
  wire pop  = do_ret;

  always_comb begin
    if (do_vector) begin
      op = PC_OP_VECTOR;
    end else if (do_call) begin
      op = PC_OP_CALL;
    end else if (do_jump) begin
      op = PC_OP_JUMP;
    end else if (do_ret) begin
      op = PC_OP_RET;
    end else if (ctl_i.exec) begin
      op = PC_OP_STEP;
    end else begin
      op = PC_OP_HOLD;
    end
  end

  // Jump target: holding bits 4:3 above the 11-bit operand.
  wire [PC_W-1:0] jump_target =
    {upper_hold_r[JUMP_HI_MSB:JUMP_HI_LSB], ctl_i.operand};

  // Low-byte write target: holding bits 4:0 above the written byte.
  wire [PC_W-1:0] low_write_target =
    {upper_hold_r[UPPER_FIELD_W-1:0], req.wdata};

  // No carry into the upper bits on a computed jump; software owns that.
  always_comb begin
    pc_nxt = pc_r;
    case (op)
      PC_OP_VECTOR: pc_nxt = ctl_i.vector_addr;
      PC_OP_CALL:   pc_nxt = jump_target;
      PC_OP_JUMP:   pc_nxt = jump_target;
      PC_OP_RET:    pc_nxt = stack_top;
      PC_OP_STEP:   pc_nxt = pc_r + PC_W'(1);
      PC_OP_HOLD:   pc_nxt = pc_r;
      default:      pc_nxt = pc_r;
    endcase
    // A write to the low byte redirects the whole counter in place of the step.
    if (wr_pc_low && (op == PC_OP_STEP || op == PC_OP_HOLD)) begin
      pc_nxt = low_write_target;
    end
  end

  // Holding register only changes on its own register write.
  assign upper_hold_nxt = wr_upper ? req.wdata : upper_hold_r;

  // Unmapped reads return zero; the stack pointer has no address.
  assign rdata_nxt = rd_pc_low ? pc_r[DATA_W-1:0] :
                     rd_upper  ? upper_hold_r :
                     '0;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_r <= PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_hold_r <= UPPER_HOLD_RESET;
      rdata_r      <= '0;
      ret_addr_r   <= PC_RESET;
    end else begin
      upper_hold_r <= upper_hold_nxt;
      rdata_r      <= rdata_nxt;
      ret_addr_r   <= stack_top;
    end
  end

  ret_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_ret_stack (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .push_i     (push),
    .pop_i      (pop),
    .push_data_i(pc_r),
    .top_o      (stack_top)
  );

  assign reg_rdata_o = rdata_r;
  assign pc_o        = pc_r;
  assign ret_addr_o  = ret_addr_r;

endmodule

// ---- bench/pc_stack_assertions.sv ----
`timescale 1ns/1ps
module pc_stack_assertions
  import pc_stack_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [DATA_W-1:0] reg_rdata_o,
  input  wire pc_ctl_t           ctl_i,
  input  wire logic [PC_W-1:0]   pc_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] hold_r;
  wire        branch = ctl_i.jump | ctl_i.call | ctl_i.vector | ctl_i.ret;
  wire        wr_lo  = reg_wr_i && reg_addr_i == ADDR_PC_LOW;
  // Shadow of the holding register, since the design never shows it except on reads.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) hold_r <= UPPER_HOLD_RESET;
    else if (reg_wr_i && reg_addr_i == ADDR_UPPER_HOLD) hold_r <= reg_wdata_i;
  end
  sequence call_s; ctl_i.exec && ctl_i.call && !ctl_i.vector; endsequence
  sequence ret_s; ctl_i.exec && ctl_i.ret && !ctl_i.call && !ctl_i.vector && !ctl_i.jump; endsequence
  lo_write_a: assert property (wr_lo && !branch |=>
    pc_o == {hold_r[4:0], $past(reg_wdata_i)}) else $error("low byte write load wrong");
  jump_call_a: assert property (ctl_i.exec && (ctl_i.jump || ctl_i.call) && !ctl_i.vector
    && !reg_wr_i |=> pc_o == {hold_r[4:3], $past(ctl_i.operand)}) else $error("jump load wrong");
  vector_a: assert property (ctl_i.exec && ctl_i.vector |=>
    pc_o == $past(ctl_i.vector_addr)) else $error("vector load wrong");
  step_a: assert property (ctl_i.exec && !branch && !wr_lo |=>
    pc_o == $past(pc_o) + 13'h0001) else $error("step wrong");
  stall_a: assert property (!ctl_i.exec && !wr_lo |=> $stable(pc_o))
    else $error("counter moved while idle");
  call_ret_a: assert property (call_s ##1 ret_s |=> pc_o == $past(pc_o, 2))
    else $error("return address wrong");
  pc_read_a: assert property (reg_rd_i && reg_addr_i == ADDR_PC_LOW && !ctl_i.exec
    && !reg_wr_i |=> reg_rdata_o == pc_o[7:0]) else $error("low byte read wrong");
  hold_read_a: assert property (reg_rd_i && reg_addr_i == ADDR_UPPER_HOLD |=>
    reg_rdata_o == hold_r) else $error("holding read wrong");
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero when idle");
endmodule
bind pc_call_stack pc_stack_assertions u_pc_stack_assertions (.clk_sys_i, .rst_b_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ctl_i, .pc_o);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", n, e, a); end end
module tb_top;
  import pc_stack_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [8:0]  addr      = 9'h000;
  logic [7:0]  wd        = 8'h00;
  logic [7:0]  rdata;
  logic [7:0]  q;
  pc_ctl_t     ctl       = '0;
  logic [12:0] pc;
  logic [12:0] ra;
  int          n_mismatch = 0;
  int          checked    = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  pc_call_stack u_pc_call_stack (.clk_sys_i, .rst_b_i, .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ctl_i(ctl), .pc_o(pc), .ret_addr_o(ra));
  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys_i); wr <= 1'b1; addr <= a; wd <= d;
  endtask
  task automatic ex(input logic [3:0] f, input logic [10:0] o);
    @(posedge clk_sys_i); ctl <= {1'b1, f, o, 13'h0004};
  endtask
  // Ends every request group, so back-to-back groups are built by chaining calls first.
  task automatic fin;
    @(posedge clk_sys_i); ctl <= '0; wr <= 1'b0; rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic rreg(input logic [8:0] a);
    @(posedge clk_sys_i); rd <= 1'b1; addr <= a; fin;
  endtask
  task automatic t_walk;
    wreg(ADDR_UPPER_HOLD, 8'h1b); wreg(ADDR_PC_LOW, 8'h10); fin;
    `CHK("pc", 13'h1b10, pc)
    rreg(ADDR_PC_LOW); `CHK("lo", 8'h10, q)
    ex(4'h4, 11'h005); fin; `CHK("call", 13'h1805, pc)
    ex(4'h1, 11'h000); fin; `CHK("ret", 13'h1b10, pc)
    `CHK("ret_addr", 13'h1b10, ra)
    ex(4'h4, 11'h005); ex(4'h1, 11'h000); fin; `CHK("ret2", 13'h1b10, pc)
    rreg(ADDR_UPPER_HOLD); `CHK("hold", 8'h1b, q)
    rreg(9'h003); `CHK("unmapped", 8'h00, q)
    $display("t_walk done");
  endtask
  task automatic t_stack;
    wreg(ADDR_UPPER_HOLD, 8'h08); fin;
    for (int i = 1; i <= 9; i++) ex(4'h4, 11'(i));
    fin;
    for (int i = 8; i >= 0; i--) begin
      ex(4'h1, 11'h000); fin;
      `CHK("pop", 13'h0800 | 13'(i == 0 ? 8 : i), pc)
    end
    ex(4'h2, 11'h000); fin; `CHK("vector", 13'h0004, pc)
    ex(4'h1, 11'h000); fin; `CHK("exit", 13'h0808, pc)
    $display("t_stack done");
  endtask
  task automatic t_step;
    wreg(ADDR_UPPER_HOLD, 8'h1f); wreg(ADDR_PC_LOW, 8'hff); fin;
    `CHK("top", 13'h1fff, pc)
    ex(4'h0, 11'h000); fin; `CHK("wrap", 13'h0000, pc)
    ex(4'h8, 11'h7ff); fin; `CHK("jump", 13'h1fff, pc)
    @(posedge clk_sys_i); rst_b_i <= 1'b0;
    #1 `CHK("reset", 13'h0000, pc)
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    // Software carries the low-byte wrap into the holding register itself.
    wreg(ADDR_UPPER_HOLD, 8'h02); wreg(ADDR_PC_LOW, 8'h00); fin;
    `CHK("carry", 13'h0200, pc)
    $display("t_step done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    #1 `CHK("reset", 13'h0000, pc)
    t_walk; t_stack; t_step; wrap_up;
  end
  // The tests need well under 200 cycles, so this only trips on a hang.
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    n_mismatch++;
    wrap_up;
  end
endmodule
